// file: rtl/serm_defs.svh
// Constants of the serial master command engine: framing bytes, limits and type codes
`ifndef SERM_DEFS_SVH
`define SERM_DEFS_SVH

`define SERM_ESC_BYTE 8'h1b
`define SERM_TAG_H 8'h48
`define SERM_TAG_R 8'h52
`define SERM_TAG_S 8'h53
`define SERM_TAG_I 8'h49
`define SERM_REPLY_MAX 32'h0000_0400
`define SERM_TEXT_MAX 32'h0000_00fa
`define SERM_HDR_LAST 3'h7
`define SERM_BIT_LAST 4'h7

`define SERM_T_S8 8'h07
`define SERM_T_U8 8'h08
`define SERM_T_S16 8'h0f
`define SERM_T_U16 8'h10
`define SERM_T_S24 8'h17
`define SERM_T_U24 8'h18
`define SERM_T_S32 8'h1f
`define SERM_T_U32 8'h20
`define SERM_T_F32 8'h21
`define SERM_T_BS16 8'h73
`define SERM_T_BU16 8'h74
`define SERM_T_BS24 8'h7b
`define SERM_T_BU24 8'h7c
`define SERM_T_BS32 8'h83
`define SERM_T_BU32 8'h84
`define SERM_T_BF32 8'h85

`define SERM_CS_LOW 2'h0
`define SERM_CS_HIGH 2'h1

`endif

// file: rtl/serm_pkg.sv
// Types and shared decode functions of the serial master command engine
package serm_pkg;
`include "serm_defs.svh"

	typedef enum logic [3:0] {
		SERM_SEND_ASCII = 4'h0,
		SERM_SEND_WIDE = 4'h1,
		SERM_SEND_INT = 4'h2,
		SERM_SEND_FLOAT = 4'h3,
		SERM_SEND_RAW = 4'h4,
		SERM_SEND_REG = 4'h5,
		SERM_SEND_ARRAY = 4'h6,
		SERM_SEND_FILE = 4'h7,
		SERM_RX_REPLY = 4'h8,
		SERM_RX_TEXT8 = 4'h9,
		SERM_RX_TEXT16 = 4'ha,
		SERM_RX_REG = 4'hb
	} serm_op_type;

	typedef enum logic [1:0] {
		SERM_PORT_RS232 = 2'h0,
		SERM_PORT_SPI = 2'h1,
		SERM_PORT_I2C = 2'h2
	} serm_port_type;

	typedef enum logic [2:0] {
		SERM_ST_IDLE = 3'h0,
		SERM_ST_FETCH = 3'h1,
		SERM_ST_EMIT = 3'h2,
		SERM_ST_HDR = 3'h3,
		SERM_ST_COPY = 3'h4,
		SERM_ST_GET = 3'h5,
		SERM_ST_STORE = 3'h6,
		SERM_ST_DONE = 3'h7
	} serm_state_type;

	// Bytes per value for a type code, zero for an unknown code
	function automatic logic [2:0] serm_type_width(input logic [7:0] code);
		case (code)
			`SERM_T_S8, `SERM_T_U8: serm_type_width = 3'h1;
			`SERM_T_S16, `SERM_T_U16, `SERM_T_BS16, `SERM_T_BU16: serm_type_width = 3'h2;
			`SERM_T_S24, `SERM_T_U24, `SERM_T_BS24, `SERM_T_BU24: serm_type_width = 3'h3;
			`SERM_T_S32, `SERM_T_U32, `SERM_T_F32,
			`SERM_T_BS32, `SERM_T_BU32, `SERM_T_BF32: serm_type_width = 3'h4;
			default: serm_type_width = 3'h0;
		endcase
	endfunction : serm_type_width

	function automatic logic serm_type_big(input logic [7:0] code);
		serm_type_big = (code >= `SERM_T_BS16);
	endfunction : serm_type_big

	function automatic logic serm_type_signed(input logic [7:0] code);
		case (code)
			`SERM_T_S8, `SERM_T_S16, `SERM_T_S24, `SERM_T_S32,
			`SERM_T_BS16, `SERM_T_BS24, `SERM_T_BS32: serm_type_signed = 1'b1;
			default: serm_type_signed = 1'b0;
		endcase
	endfunction : serm_type_signed

	function automatic logic [7:0] serm_byte_of(input logic [31:0] word, input logic [1:0] idx);
		serm_byte_of = 8'((word >> {idx, 3'h0}));
	endfunction : serm_byte_of

endpackage : serm_pkg

// file: rtl/serm_stream_if.sv
// Valid/ready byte stream between the engine, its FIFOs and the bit shifter
`timescale 1ns/10ps
interface serm_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : serm_stream_if

// file: rtl/serm_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a fill level
`timescale 1ns/10ps
module serm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	serm_stream_if.snk in_s,
	serm_stream_if.src out_s,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
		begin : g_bad
			$error("serm_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign push = in_s.valid && !full;
	assign pop = out_s.ready && !empty;
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem_reg[rd_ptr_reg[AW-1:0]];
	assign level_o = wr_ptr_reg - rd_ptr_reg;

	always_ff @(posedge clk_sys_i)
	begin
		if (push)
		begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_s.data;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule : serm_fifo

// file: rtl/serm_shifter.sv
// Master byte shifter paced by the sampled link clock, with chip select control
`timescale 1ns/10ps
module serm_shifter
	import serm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic link_clk_i,
	input wire logic miso_i,
	input wire logic [1:0] cs_mode_i,
	serm_stream_if.snk tx_in,
	serm_stream_if.src rx_out,
	output logic mosi_o,
	output logic cs_n_o
);
	logic lclk_meta_reg;
	logic lclk_sync_reg;
	logic lclk_prev_reg;
	logic miso_meta_reg;
	logic miso_sync_reg;
	logic active_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] rx_shift_reg;
	logic rx_valid_reg;
	logic [7:0] rx_data_reg;
	logic rise;
	logic fall;
	logic start;

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			lclk_meta_reg <= 1'b0;
			lclk_sync_reg <= 1'b0;
			lclk_prev_reg <= 1'b0;
			miso_meta_reg <= 1'b0;
			miso_sync_reg <= 1'b0;
		end
		else
		begin
			lclk_meta_reg <= link_clk_i;
			lclk_sync_reg <= lclk_meta_reg;
			lclk_prev_reg <= lclk_sync_reg;
			miso_meta_reg <= miso_i;
			miso_sync_reg <= miso_meta_reg;
		end
	end

	assign rise = lclk_sync_reg && !lclk_prev_reg;
	assign fall = !lclk_sync_reg && lclk_prev_reg;
	// A byte starts only when the receive side has room for the byte coming back
	assign tx_in.ready = !active_reg && rx_out.ready && !rx_valid_reg;
	assign start = tx_in.valid && tx_in.ready;
	assign rx_out.valid = rx_valid_reg;
	assign rx_out.data = rx_data_reg;

	// Whole byte out, most significant bit first, before the next one
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			active_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			tx_shift_reg <= 8'h00;
			rx_shift_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			mosi_o <= 1'b0;
		end
		else
		begin
			rx_valid_reg <= 1'b0;
			if (start)
			begin
				active_reg <= 1'b1;
				bit_cnt_reg <= 4'h0;
				tx_shift_reg <= tx_in.data;
				mosi_o <= tx_in.data[7];
			end
			else if (active_reg)
			begin
				if (rise)
				begin
					rx_shift_reg <= {rx_shift_reg[6:0], miso_sync_reg};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == `SERM_BIT_LAST)
					begin
						active_reg <= 1'b0;
						rx_valid_reg <= 1'b1;
						rx_data_reg <= {rx_shift_reg[6:0], miso_sync_reg};
					end
				end
				else if (fall && bit_cnt_reg != 4'h0)
				begin
					tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
					mosi_o <= tx_shift_reg[6];
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			cs_n_o <= 1'b1;
		end
		else
		begin
			case (cs_mode_i)
				`SERM_CS_LOW: cs_n_o <= 1'b0;
				`SERM_CS_HIGH: cs_n_o <= 1'b1;
				default: cs_n_o <= !(active_reg || start);
			endcase
		end
	end
endmodule : serm_shifter

// file: rtl/serm_engine.sv
// Serial master command engine: host commands to master port bytes and back
// Summary of operation
// - ASCII send: one byte per character
// - Wide string send: two bytes per character
// - Integer send: 32-bit, least significant byte first
// - Float send: 32-bit, least significant byte first
// - Raw send: given byte count, unchanged
// - Register send: width and order from type
// - Array send: from start index, same encoding
// - File send: stream stored file bytes
// - Reply receive: move count bytes to send buffer
// - Reply framed: ESC, H, port, R, length, data
// - Byte receive: bytes into text slot
// - Word receive: 16-bit words, count at most 250
// - Typed receive: decode width, order into register
// - Used port stops serving as slave
// - Reply receive count at most 1024
// - Chip select low, high or automatic
`timescale 1ns/10ps
module serm_engine
	import serm_pkg::*;
#(
	parameter int FIFO_WIDTH = 8,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_op_i,
	input wire logic [1:0] cmd_port_i,
	input wire logic [7:0] cmd_type_i,
	input wire logic [7:0] cmd_slot_i,
	input wire logic [31:0] cmd_count_i,
	input wire logic [15:0] cmd_start_i,
	output logic cmd_ready_o,
	input wire logic data_valid_i,
	input wire logic [31:0] data_i,
	output logic data_ready_o,
	output logic [15:0] elem_index_o,
	output logic reply_valid_o,
	output logic [7:0] reply_data_o,
	input wire logic reply_ready_i,
	output logic store_valid_o,
	output logic [7:0] store_slot_o,
	output logic [15:0] store_index_o,
	output logic [31:0] store_data_o,
	output logic done_o,
	output logic error_o,
	output logic [2:0] port_master_o,
	output logic [$clog2(FIFO_DEPTH):0] rx_level_o,
	input wire logic [1:0] cs_mode_i,
	input wire logic link_clk_i,
	input wire logic miso_i,
	output logic mosi_o,
	output logic cs_n_o
);
	generate
		if (FIFO_WIDTH != 8)
		begin : g_bad_width
			$error("serm_engine: the byte path needs FIFO_WIDTH of 8");
		end
	endgenerate

	serm_stream_if #(.WIDTH(FIFO_WIDTH)) eng_tx ();
	serm_stream_if #(.WIDTH(FIFO_WIDTH)) tx_out ();
	serm_stream_if #(.WIDTH(FIFO_WIDTH)) rx_in ();
	serm_stream_if #(.WIDTH(FIFO_WIDTH)) rx_out ();

	serm_state_type state_reg;
	serm_op_type op_reg;
	serm_port_type port_reg;
	logic [7:0] type_reg;
	logic [31:0] count_reg;
	logic [15:0] index_reg;
	logic [31:0] word_reg;
	logic [2:0] width_reg;
	logic big_reg;
	logic [2:0] bidx_reg;
	logic [$clog2(FIFO_DEPTH):0] rx_level;

	logic accept;
	logic [2:0] acc_width;
	logic acc_bad;
	logic [2:0] emit_sel;
	logic [7:0] hdr_byte;
	logic reply_free;
	logic data_take;
	logic last_byte;

	////////////////////////////////////////////////////////////////////////////////
	// Byte FIFOs and master shifter

	serm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_s(eng_tx.snk),
		.out_s(tx_out.src),
		.level_o()
	);

	serm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_s(rx_in.snk),
		.out_s(rx_out.src),
		.level_o(rx_level)
	);

	serm_shifter u_shifter (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.link_clk_i(link_clk_i),
		.miso_i(miso_i),
		.cs_mode_i(cs_mode_i),
		.tx_in(tx_out.snk),
		.rx_out(rx_in.src),
		.mosi_o(mosi_o),
		.cs_n_o(cs_n_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	assign accept = cmd_valid_i && cmd_ready_o;

	always_comb
	begin
		case (cmd_op_i)
			SERM_SEND_ASCII: acc_width = 3'h1;
			SERM_SEND_RAW: acc_width = 3'h1;
			SERM_SEND_FILE: acc_width = 3'h1;
			SERM_RX_REPLY: acc_width = 3'h1;
			SERM_RX_TEXT8: acc_width = 3'h1;
			SERM_SEND_WIDE: acc_width = 3'h2;
			SERM_RX_TEXT16: acc_width = 3'h2;
			SERM_SEND_INT: acc_width = 3'h4;
			SERM_SEND_FLOAT: acc_width = 3'h4;
			SERM_SEND_REG: acc_width = serm_type_width(cmd_type_i);
			SERM_SEND_ARRAY: acc_width = serm_type_width(cmd_type_i);
			SERM_RX_REG: acc_width = serm_type_width(cmd_type_i);
			default: acc_width = 3'h0;
		endcase
	end

	always_comb
	begin
		acc_bad = (acc_width == 3'h0) || (cmd_port_i == 2'h3);
		if (cmd_op_i == SERM_RX_REPLY && cmd_count_i > `SERM_REPLY_MAX)
		begin
			acc_bad = 1'b1;
		end
		if ((cmd_op_i == SERM_RX_TEXT8 || cmd_op_i == SERM_RX_TEXT16) &&
			cmd_count_i > `SERM_TEXT_MAX)
		begin
			acc_bad = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outgoing bytes and reply header

	// Little endian walks bytes upward, big endian downward
	assign emit_sel = big_reg ? 3'(width_reg - 3'h1 - bidx_reg) : bidx_reg;
	assign eng_tx.valid = (state_reg == SERM_ST_EMIT);
	assign eng_tx.data = serm_byte_of(word_reg, emit_sel[1:0]);
	assign last_byte = (bidx_reg == 3'(width_reg - 3'h1));
	assign data_take = data_valid_i && data_ready_o;
	assign reply_free = !reply_valid_o || reply_ready_i;
	assign rx_out.ready = (state_reg == SERM_ST_GET) ||
		(state_reg == SERM_ST_COPY && reply_free);

	always_comb
	begin
		case (bidx_reg)
			3'h0: hdr_byte = `SERM_ESC_BYTE;
			3'h1: hdr_byte = `SERM_TAG_H;
			3'h2:
			begin
				case (port_reg)
					SERM_PORT_RS232: hdr_byte = `SERM_TAG_R;
					SERM_PORT_SPI: hdr_byte = `SERM_TAG_S;
					default: hdr_byte = `SERM_TAG_I;
				endcase
			end
			3'h3: hdr_byte = `SERM_TAG_R;
			default: hdr_byte = serm_byte_of(count_reg, 2'(bidx_reg - 3'h4));
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			state_reg <= SERM_ST_IDLE;
			op_reg <= SERM_SEND_ASCII;
			port_reg <= SERM_PORT_RS232;
			type_reg <= 8'h00;
			count_reg <= 32'h0000_0000;
			index_reg <= 16'h0000;
			word_reg <= 32'h0000_0000;
			width_reg <= 3'h0;
			big_reg <= 1'b0;
			bidx_reg <= 3'h0;
			cmd_ready_o <= 1'b0;
		end
		else
		begin
			case (state_reg)
				SERM_ST_IDLE:
				begin
					cmd_ready_o <= 1'b1;
					if (accept && !acc_bad)
					begin
						cmd_ready_o <= 1'b0;
						op_reg <= serm_op_type'(cmd_op_i);
						port_reg <= serm_port_type'(cmd_port_i);
						type_reg <= cmd_type_i;
						count_reg <= cmd_count_i;
						index_reg <= cmd_start_i;
						width_reg <= acc_width;
						big_reg <= (cmd_op_i == SERM_SEND_REG || cmd_op_i == SERM_SEND_ARRAY ||
							cmd_op_i == SERM_RX_REG) && serm_type_big(cmd_type_i);
						word_reg <= 32'h0000_0000;
						bidx_reg <= 3'h0;
						if (cmd_count_i == 32'h0000_0000)
						begin
							state_reg <= SERM_ST_DONE;
						end
						else if (cmd_op_i == SERM_RX_REPLY)
						begin
							state_reg <= SERM_ST_HDR;
						end
						else if (cmd_op_i >= SERM_RX_TEXT8)
						begin
							state_reg <= SERM_ST_GET;
						end
						else
						begin
							state_reg <= SERM_ST_FETCH;
						end
					end
				end
				SERM_ST_FETCH:
				begin
					if (data_take)
					begin
						word_reg <= data_i;
						bidx_reg <= 3'h0;
						state_reg <= SERM_ST_EMIT;
					end
				end
				SERM_ST_EMIT:
				begin
					if (eng_tx.ready)
					begin
						bidx_reg <= bidx_reg + 3'h1;
						if (last_byte)
						begin
							bidx_reg <= 3'h0;
							index_reg <= index_reg + 16'h0001;
							count_reg <= count_reg - 32'h0000_0001;
							state_reg <= (count_reg == 32'h0000_0001) ? SERM_ST_DONE
								: SERM_ST_FETCH;
						end
					end
				end
				SERM_ST_HDR:
				begin
					if (reply_free)
					begin
						bidx_reg <= bidx_reg + 3'h1;
						if (bidx_reg == `SERM_HDR_LAST)
						begin
							state_reg <= SERM_ST_COPY;
						end
					end
				end
				SERM_ST_COPY:
				begin
					if (rx_out.valid && reply_free)
					begin
						count_reg <= count_reg - 32'h0000_0001;
						if (count_reg == 32'h0000_0001)
						begin
							state_reg <= SERM_ST_DONE;
						end
					end
				end
				SERM_ST_GET:
				begin
					if (rx_out.valid)
					begin
						if (big_reg)
						begin
							word_reg <= {word_reg[23:0], rx_out.data};
						end
						else
						begin
							word_reg <= word_reg | (32'(rx_out.data) << {bidx_reg, 3'h0});
						end
						bidx_reg <= bidx_reg + 3'h1;
						if (last_byte)
						begin
							state_reg <= SERM_ST_STORE;
						end
					end
				end
				SERM_ST_STORE:
				begin
					word_reg <= 32'h0000_0000;
					bidx_reg <= 3'h0;
					index_reg <= index_reg + 16'h0001;
					count_reg <= count_reg - 32'h0000_0001;
					state_reg <= (count_reg == 32'h0000_0001) ? SERM_ST_DONE : SERM_ST_GET;
				end
				SERM_ST_DONE:
				begin
					cmd_ready_o <= 1'b1;
					state_reg <= SERM_ST_IDLE;
				end
				default:
				begin
					state_reg <= SERM_ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host-facing strobes and status

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			data_ready_o <= 1'b0;
			elem_index_o <= 16'h0000;
			done_o <= 1'b0;
			error_o <= 1'b0;
			port_master_o <= 3'h0;
			rx_level_o <= '0;
		end
		else
		begin
			data_ready_o <= (state_reg == SERM_ST_FETCH) && !data_take;
			elem_index_o <= index_reg;
			done_o <= (state_reg == SERM_ST_DONE);
			error_o <= accept && acc_bad && (state_reg == SERM_ST_IDLE);
			rx_level_o <= rx_level;
			if (accept && !acc_bad && state_reg == SERM_ST_IDLE)
			begin
				port_master_o[cmd_port_i] <= 1'b1;
			end
		end
	end

	// Received values, sign extended for signed type codes on typed receive only
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			store_valid_o <= 1'b0;
			store_slot_o <= 8'h00;
			store_index_o <= 16'h0000;
			store_data_o <= 32'h0000_0000;
		end
		else
		begin
			store_valid_o <= (state_reg == SERM_ST_STORE);
			if (state_reg == SERM_ST_STORE)
			begin
				store_slot_o <= type_reg == 8'h00 ? store_slot_o : store_slot_o;
				store_index_o <= index_reg;
				store_data_o <= word_reg;
				if (op_reg == SERM_RX_REG && serm_type_signed(type_reg))
				begin
					case (width_reg)
						3'h1: store_data_o <= {{24{word_reg[7]}}, word_reg[7:0]};
						3'h2: store_data_o <= {{16{word_reg[15]}}, word_reg[15:0]};
						3'h3: store_data_o <= {{8{word_reg[23]}}, word_reg[23:0]};
						default: store_data_o <= word_reg;
					endcase
				end
			end
			if (accept && state_reg == SERM_ST_IDLE)
			begin
				store_slot_o <= cmd_slot_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			reply_valid_o <= 1'b0;
			reply_data_o <= 8'h00;
		end
		else if (reply_free)
		begin
			reply_valid_o <= 1'b0;
			if (state_reg == SERM_ST_HDR)
			begin
				reply_valid_o <= 1'b1;
				reply_data_o <= hdr_byte;
			end
			else if (state_reg == SERM_ST_COPY && rx_out.valid)
			begin
				reply_valid_o <= 1'b1;
				reply_data_o <= rx_out.data;
			end
		end
	end
endmodule : serm_engine

// file: test/serm_engine_props.sv
// Concurrent checks on the ports of the serial master command engine
`timescale 1ns/10ps
module serm_engine_props (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_op_i,
	input wire logic [31:0] cmd_count_i,
	input wire logic cmd_ready_o,
	input wire logic data_valid_i,
	input wire logic data_ready_o,
	input wire logic reply_valid_o,
	input wire logic [7:0] reply_data_o,
	input wire logic reply_ready_i,
	input wire logic done_o,
	input wire logic error_o,
	input wire logic [2:0] port_master_o,
	input wire logic [1:0] cs_mode_i,
	input wire logic cs_n_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	wire take = cmd_valid_i && cmd_ready_o;
	property p_reply_max;
		take && cmd_op_i == 4'h8 && cmd_count_i > 32'h0000_0400 |=> error_o && cmd_ready_o;
	endproperty
	a_reply_max: assert property (p_reply_max) else $error("reply count over limit");
	property p_text_max;
		take && cmd_op_i == 4'ha && cmd_count_i > 32'h0000_00fa |=> error_o && cmd_ready_o;
	endproperty
	a_text_max: assert property (p_text_max) else $error("word count over limit");
	property p_take;
		take |=> !cmd_ready_o || error_o;
	endproperty
	a_take: assert property (p_take) else $error("command taken without effect");
	property p_done;
		done_o |-> cmd_ready_o && !$past(cmd_ready_o) ##1 !done_o;
	endproperty
	a_done: assert property (p_done) else $error("done pulse malformed");
	property p_master_sticky;
		##1 1'b1 |-> (port_master_o & $past(port_master_o)) == $past(port_master_o);
	endproperty
	a_master_sticky: assert property (p_master_sticky) else $error("port master lost");
	property p_cs_fixed;
		(cs_mode_i == 2'h0)[*4] |-> !cs_n_o ##0 (cs_mode_i != 2'h1 || cs_n_o);
	endproperty
	a_cs_fixed: assert property (p_cs_fixed) else $error("chip select not low");
	property p_cs_high;
		(cs_mode_i == 2'h1)[*4] |-> cs_n_o;
	endproperty
	a_cs_high: assert property (p_cs_high) else $error("chip select not high");
	property p_reply_hold;
		reply_valid_o && !reply_ready_i |=> reply_valid_o && $stable(reply_data_o);
	endproperty
	a_reply_hold: assert property (p_reply_hold) else $error("reply byte dropped");
	property p_data_take;
		data_valid_i && data_ready_o |=> !data_ready_o;
	endproperty
	a_data_take: assert property (p_data_take) else $error("value taken twice");
endmodule : serm_engine_props

bind serm_engine serm_engine_props chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_count_i(cmd_count_i),
	.cmd_ready_o(cmd_ready_o), .data_valid_i(data_valid_i), .data_ready_o(data_ready_o),
	.reply_valid_o(reply_valid_o), .reply_data_o(reply_data_o),
	.reply_ready_i(reply_ready_i), .done_o(done_o), .error_o(error_o),
	.port_master_o(port_master_o), .cs_mode_i(cs_mode_i), .cs_n_o(cs_n_o));

// file: test/serm_peer.sv
// Serial peripheral model: clocks bytes for as long as chip select stays low, full duplex
`timescale 1ns/10ps
module serm_peer (
	input wire logic en_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic link_clk_o,
	output logic miso_o
);
	logic [7:0] nxt = 8'hc0;
	logic [7:0] sh;
	logic [7:0] got;
	logic [7:0] q[$];
	int i;
	initial
	begin
		link_clk_o = 1'b0;
		miso_o = 1'b0;
		forever
		begin
			@(negedge cs_n_i);
			// Back-to-back bytes: select may fall again before the last byte is logged
			while (en_i && cs_n_i === 1'b0)
			begin
				sh = nxt;
				nxt = nxt + 8'h01;
				miso_o = sh[7];
				#40;
				for (i = 7; i >= 0; i--)
				begin
					link_clk_o = 1'b1;
					got = {got[6:0], mosi_i};
					#32;
					link_clk_o = 1'b0;
					if (i > 0)
						miso_o = sh[i-1];
					#32;
				end
				q.push_back(got);
				// Released line shows the inverse, not a held value
				miso_o = ~miso_o;
			end
		end
	end
endmodule : serm_peer

// file: test/testbench.sv
// Self-checking bench of the serial master command engine
`timescale 1ns/10ps
module testbench;
	import serm_pkg::*;
	logic clk_sys_i = 0, reset_i = 1, cmd_valid_i = 0, data_valid_i = 0, reply_ready_i = 0;
	logic [3:0] cmd_op_i = 0;
	logic [1:0] cmd_port_i = 0, cs_mode_i = 2'h2;
	logic [7:0] cmd_type_i = 0, cmd_slot_i = 0;
	logic [31:0] cmd_count_i = 0, data_i = 0;
	logic [15:0] cmd_start_i = 16'h0007;
	logic cmd_ready_o, data_ready_o, reply_valid_o, store_valid_o, done_o, error_o;
	logic mosi_o, cs_n_o, link_clk_i, miso_i;
	logic [15:0] elem_index_o, store_index_o;
	logic [7:0] reply_data_o, store_slot_o;
	logic [31:0] store_data_o;
	logic [2:0] port_master_o;
	logic [5:0] rx_level_o;
	logic [7:0] rq[$];
	int n_fail = 0, checks = 0, i;
	serm_engine dut (.clk_sys_i, .reset_i, .cmd_valid_i, .cmd_op_i, .cmd_port_i, .cmd_type_i,
		.cmd_slot_i, .cmd_count_i, .cmd_start_i, .cmd_ready_o, .data_valid_i, .data_i,
		.data_ready_o, .elem_index_o, .reply_valid_o, .reply_data_o, .reply_ready_i,
		.store_valid_o, .store_slot_o, .store_index_o, .store_data_o, .done_o, .error_o,
		.port_master_o, .rx_level_o, .cs_mode_i, .link_clk_i, .miso_i, .mosi_o, .cs_n_o);
	serm_peer peer (.en_i(cs_mode_i == 2'h2), .cs_n_i(cs_n_o), .mosi_i(mosi_o),
		.link_clk_o(link_clk_i), .miso_o(miso_i));
	initial
	begin
		forever
			#4 clk_sys_i = ~clk_sys_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Waits at falling edges for 0 cmd ready, 1 data ready, 2 done, 3 error, 4 store
	task waitfor(input int which);
		int n;
		for (n = 0; n < 5000; n++)
		begin
			@(negedge clk_sys_i);
			case (which)
				0: if (cmd_ready_o === 1'b1) return;
				1: if (data_ready_o === 1'b1) return;
				2: if (done_o === 1'b1) return;
				3: if (error_o === 1'b1) return;
				default: if (store_valid_o === 1'b1) return;
			endcase
		end
		n_fail++;
		$display("BAD t=%0t wait %h timed out exp=%h", $time, which, 1);
		report_and_stop();
	endtask : waitfor
	task cmd(input logic [3:0] op, input logic [1:0] port, input logic [7:0] ty,
		input logic [31:0] cnt);
		@(posedge clk_sys_i);
		cmd_op_i <= op;
		cmd_port_i <= port;
		cmd_type_i <= ty;
		cmd_slot_i <= 8'h05;
		cmd_count_i <= cnt;
		cmd_valid_i <= 1'b1;
		waitfor(0);
		@(posedge clk_sys_i);
		cmd_valid_i <= 1'b0;
	endtask : cmd
	task feed(input logic [31:0] v);
		@(posedge clk_sys_i);
		data_i <= v;
		data_valid_i <= 1'b1;
		waitfor(1);
		@(posedge clk_sys_i);
		data_valid_i <= 1'b0;
	endtask : feed
	task txq(input logic [7:0] e[$]);
		for (i = 0; i < 20000 && peer.q.size() < e.size(); i++)
			@(posedge clk_sys_i);
		chk(peer.q.size(), e.size());
		foreach (e[k])
			chk(peer.q[k], e[k]);
		peer.q.delete();
	endtask : txq
	////////////////////////////////////////////////////////////////////////////////
	task t_sends;
		cmd(4'h2, 2'h1, 8'h00, 32'h2);
		feed(32'h1234_5678);
		feed(32'h89ab_cdef);
		waitfor(2);
		txq('{8'h78, 8'h56, 8'h34, 8'h12, 8'hef, 8'hcd, 8'hab, 8'h89});
		cmd(4'h1, 2'h1, 8'h00, 32'h1);
		feed(32'h0000_4142);
		waitfor(2);
		txq('{8'h42, 8'h41});
		cmd(4'h5, 2'h1, 8'h7b, 32'h1);
		feed(32'h00a1_b2c3);
		waitfor(2);
		txq('{8'ha1, 8'hb2, 8'hc3});
		chk(elem_index_o, 16'h0008);
		$display("test sends done");
	endtask : t_sends
	task t_refuse;
		cmd(4'h8, 2'h0, 8'h00, 32'h0000_0401);
		waitfor(3);
		chk(cmd_ready_o, 1'b1);
		cmd(4'ha, 2'h0, 8'h00, 32'h0000_00fb);
		waitfor(3);
		chk(cmd_ready_o, 1'b1);
		$display("test refuse done");
	endtask : t_refuse
	task t_reply;
		logic seen_done;
		seen_done = 1'b0;
		cmd(4'h8, 2'h0, 8'h00, 32'h2);
		for (i = 0; i < 4000 && rq.size() < 10; i++)
		begin
			@(posedge clk_sys_i);
			reply_ready_i <= i[0];
			@(negedge clk_sys_i);
			// Done may pulse while the last reply byte still waits for the consumer
			if (done_o === 1'b1)
				seen_done = 1'b1;
			if (reply_valid_o === 1'b1 && reply_ready_i)
				rq.push_back(reply_data_o);
		end
		@(posedge clk_sys_i);
		reply_ready_i <= 1'b0;
		chk(rq.size(), 10);
		foreach (rq[k])
			chk(rq[k], {8'h1b, 8'h48, 8'h52, 8'h52, 8'h02, 24'h0, 8'hc0, 8'hc1}
				>> (72 - 8 * k) & 8'hff);
		if (!seen_done)
			waitfor(2);
		cmd(4'h9, 2'h0, 8'h00, 32'h1);
		waitfor(4);
		chk(store_data_o, 32'h0000_00c2);
		chk(store_slot_o, 8'h05);
		chk(store_index_o, 16'h0007);
		chk(rx_level_o, 32'h0000_000a);
		chk(port_master_o, 3'h3);
		$display("test reply done");
	endtask : t_reply
	task t_cs;
		@(posedge clk_sys_i);
		cs_mode_i <= 2'h0;
		repeat (8) @(posedge clk_sys_i);
		chk(cs_n_o, 1'b0);
		cs_mode_i <= 2'h1;
		repeat (8) @(posedge clk_sys_i);
		chk(cs_n_o, 1'b1);
		cs_mode_i <= 2'h2;
		$display("test chip select done");
	endtask : t_cs
	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t_sends();
		t_refuse();
		t_reply();
		t_cs();
		report_and_stop();
	end
endmodule : testbench
